// file: hw/dht_timer.sv
// The implementer's own choices: the register offsets and the strobed register port.
`timescale 1ns/100ps
module dht_timer
  import dht_pkg::*;
(
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [DATA_W-1:0] rdata_o,
  input wire logic tin_i,
  output logic tout_lo_o,
  output logic tout_hi_o,
  output logic wd_flag_o
);
  function automatic logic run_on(input logic [1:0] f);
    return f != RUN_OFF;
  endfunction : run_on

  logic [31:0] cnt_lo_ff, cnt_hi_ff, prd_lo_ff, prd_hi_ff, tcw_ff, gcw_ff;
  logic [31:0] rdata_ff;
  logic [7:0] pre_ff;
  logic tin_s1_ff, tin_s2_ff, pin_prev_ff, wd_flag_ff, wd_armed_ff;
  dht_wdk_t wdk_ff;
  logic [1:0] tout_ff;

  // Register decode
  wire wr_cnt_lo = wr_i && addr_i == ADR_CNT_LO;
  wire wr_cnt_hi = wr_i && addr_i == ADR_CNT_HI;
  wire wr_tcw = wr_i && addr_i == ADR_TCW;
  wire wr_gcw = wr_i && addr_i == ADR_GCW;
  wire wr_wdcw = wr_i && addr_i == ADR_WDCW;
  wire [15:0] key_in = wdata_i[WDCW_KEY +: 16];

  // Field decode
  dht_mode_t mode;
  assign mode = dht_mode_t'(gcw_ff[GCW_MODE +: 2]);
  wire wide = mode == MODE_GP64 || mode == MODE_WATCHDOG;
  wire lo_live = gcw_ff[GCW_LO_RUN_N];
  wire hi_live = gcw_ff[GCW_HI_RUN_N];
  wire [1:0] run_lo = tcw_ff[TCW_RUN +: 2];
  wire [1:0] run_hi = tcw_ff[HALF_OFS + TCW_RUN +: 2];
  wire src_pin = tcw_ff[TCW_SRC];
  wire gate_on = tcw_ff[TCW_GATE];
  wire [7:0] psc = gcw_ff[GCW_PSC +: 8];

  // Pin path, synchronised first
  wire pin_lvl = tin_s2_ff ^ (src_pin & tcw_ff[TCW_INVIN]);
  wire pin_rise = pin_lvl & ~pin_prev_ff;
  wire lo_tick = src_pin ? pin_rise : (!gate_on || tin_s2_ff);

  // Enables
  wire wd_mode = mode == MODE_WATCHDOG;
  wire wide_en = wd_mode ? (wd_armed_ff && !wd_flag_ff) : run_on(run_lo);
  wire lo_en = wide ? (wide_en && lo_live && hi_live) : (run_on(run_lo) && lo_live);
  wire hi_en = !wide && run_on(run_hi) && hi_live;

  // 64-bit path
  wire [63:0] cnt64 = {cnt_hi_ff, cnt_lo_ff};
  wire [63:0] prd64 = {prd_hi_ff, prd_lo_ff};
  wire step64 = wide && lo_en && lo_tick;
  wire evt64 = step64 && cnt64 == prd64;
  wire cont64 = wd_mode || run_lo == RUN_CONT; // Expired watchdog restarts at zero
  wire [63:0] inc64 = cnt64 + 64'h0000_0000_0000_0001;
  wire wd_service = wd_mode && wr_wdcw && wdk_ff == WDK_FIRST
                    && key_in == WD_KEY_SECOND;
  wire [63:0] nxt_cnt64 = wd_service ? 64'h0000_0000_0000_0000 :
                          !step64 ? cnt64 :
                          evt64 ? (cont64 ? 64'h0000_0000_0000_0000 : cnt64) : inc64;

  // Dual paths
  wire step_lo = !wide && lo_en && lo_tick;
  wire lo_evt = step_lo && cnt_lo_ff == prd_lo_ff;
  wire hi_src = mode == MODE_DUAL_CHAIN ? lo_evt : 1'b1;
  wire pre_hit = pre_ff == psc;
  wire step_hi = hi_en && hi_src && pre_hit;
  wire hi_evt = step_hi && cnt_hi_ff == prd_hi_ff;
  wire [31:0] nxt_lo_dual = !step_lo ? cnt_lo_ff :
                            lo_evt ? (run_lo == RUN_CONT ? WORD_ZERO : cnt_lo_ff) :
                            cnt_lo_ff + WORD_ONE;
  wire [31:0] nxt_hi_dual = !step_hi ? cnt_hi_ff :
                            hi_evt ? (run_hi == RUN_CONT ? WORD_ZERO : cnt_hi_ff) :
                            cnt_hi_ff + WORD_ONE;

  // Counter next values: half reset beats a load, a load beats counting
  wire [31:0] nxt_cnt_lo = !lo_live ? WORD_ZERO : wr_cnt_lo ? wdata_i :
                           wide ? nxt_cnt64[31:0] : nxt_lo_dual;
  wire [31:0] nxt_cnt_hi = !hi_live ? WORD_ZERO : wr_cnt_hi ? wdata_i :
                           wide ? nxt_cnt64[63:32] : nxt_hi_dual;
  wire [7:0] nxt_pre = (!hi_en || !hi_src) ? (hi_en ? pre_ff : PSC_ZERO) :
                       pre_hit ? PSC_ZERO : pre_ff + 8'h01;

  // One-shot end clears the run field; a same-cycle software write wins
  wire end_lo = (wide ? (evt64 && !wd_mode) : lo_evt) && run_lo == RUN_ONCE;
  wire end_hi = hi_evt && run_hi == RUN_ONCE;
  logic [31:0] nxt_tcw;
  always_comb begin
    nxt_tcw = tcw_ff;
    if (end_lo) begin
      nxt_tcw[TCW_RUN +: 2] = RUN_OFF;
    end
    if (end_hi) begin
      nxt_tcw[HALF_OFS + TCW_RUN +: 2] = RUN_OFF;
    end
    if (wr_tcw) begin
      nxt_tcw = wdata_i & TCW_WMASK;
    end
  end

  // Watchdog key sequence and flag
  wire wd_timeout = wd_mode && evt64;
  wire flag_clr = wr_wdcw && wdata_i[WDCW_FLAG];
  wire nxt_wd_flag = wd_timeout || (wd_flag_ff && !flag_clr);
  dht_wdk_t nxt_wdk;
  assign nxt_wdk = !wr_wdcw ? wdk_ff :
                   key_in == WD_KEY_FIRST ? WDK_FIRST : WDK_IDLE;
  wire nxt_wd_armed = wd_mode && (wd_armed_ff || wd_service);

  // Output stage per half
  wire [1:0] evt_h = {wide ? evt64 : hi_evt, wide ? evt64 : lo_evt};
  wire [1:0] lvl_h;
  genvar h;
  generate
    for (h = 0; h < 2; h++) begin : g_out
      logic pul_on_ff, clk_lvl_ff;
      logic [1:0] pul_left_ff;
      wire cp = tcw_ff[h*HALF_OFS + TCW_CP];
      wire [1:0] pw = tcw_ff[h*HALF_OFS + TCW_PW +: 2];
      wire inv = tcw_ff[h*HALF_OFS + TCW_INVO];
      wire nxt_pul_on = evt_h[h] || (pul_on_ff && pul_left_ff != PW_ZERO);
      wire [1:0] nxt_pul_left = evt_h[h] ? pw :
                                pul_on_ff ? pul_left_ff - 2'h1 : PW_ZERO;
      wire nxt_clk_lvl = clk_lvl_ff ^ evt_h[h];
      assign lvl_h[h] = (cp ? clk_lvl_ff : pul_on_ff) ^ inv;
      always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          pul_on_ff <= 1'b0;
          pul_left_ff <= PW_ZERO;
          clk_lvl_ff <= 1'b0;
          tout_ff[h] <= 1'b0;
        end else begin
          pul_on_ff <= nxt_pul_on;
          pul_left_ff <= nxt_pul_left;
          clk_lvl_ff <= nxt_clk_lvl;
          tout_ff[h] <= lvl_h[h];
        end
      end
    end
  endgenerate

  // Read mux
  wire [31:0] stat_word = {28'h000_0000, tout_ff[1], tout_ff[0],
                           wide ? lo_en : hi_en, lo_en};
  wire [31:0] wdcw_word = {16'h0000, wd_flag_ff, wd_armed_ff, 14'h0000};
  logic [31:0] rd_mux;
  always_comb begin
    case (addr_i)
      ADR_CNT_LO: rd_mux = cnt_lo_ff;
      ADR_CNT_HI: rd_mux = cnt_hi_ff;
      ADR_PRD_LO: rd_mux = prd_lo_ff;
      ADR_PRD_HI: rd_mux = prd_hi_ff;
      ADR_TCW: rd_mux = tcw_ff;
      ADR_GCW: rd_mux = gcw_ff;
      ADR_WDCW: rd_mux = wdcw_word;
      ADR_STAT: rd_mux = stat_word;
      default: rd_mux = WORD_ZERO;
    endcase
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tin_s1_ff <= 1'b0;
      tin_s2_ff <= 1'b0;
      pin_prev_ff <= 1'b0;
    end else begin
      tin_s1_ff <= tin_i;
      tin_s2_ff <= tin_s1_ff;
      pin_prev_ff <= pin_lvl;
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_lo_ff <= WORD_ZERO;
      cnt_hi_ff <= WORD_ZERO;
      pre_ff <= PSC_ZERO;
    end else begin
      cnt_lo_ff <= nxt_cnt_lo;
      cnt_hi_ff <= nxt_cnt_hi;
      pre_ff <= nxt_pre;
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      prd_lo_ff <= WORD_ZERO;
      prd_hi_ff <= WORD_ZERO;
      tcw_ff <= WORD_ZERO;
      gcw_ff <= WORD_ZERO;
    end else begin
      if (wr_i && addr_i == ADR_PRD_LO) begin
        prd_lo_ff <= wdata_i;
      end
      if (wr_i && addr_i == ADR_PRD_HI) begin
        prd_hi_ff <= wdata_i;
      end
      if (wr_gcw) begin
        gcw_ff <= wdata_i & GCW_WMASK;
      end
      tcw_ff <= nxt_tcw;
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wd_flag_ff <= 1'b0;
      wd_armed_ff <= 1'b0;
      wdk_ff <= WDK_IDLE;
      rdata_ff <= WORD_ZERO;
    end else begin
      wd_flag_ff <= nxt_wd_flag;
      wd_armed_ff <= nxt_wd_armed;
      wdk_ff <= nxt_wdk;
      rdata_ff <= rd_i ? rd_mux : WORD_ZERO;
    end
  end

  assign rdata_o = rdata_ff;
  assign tout_lo_o = tout_ff[0];
  assign tout_hi_o = tout_ff[1];
  assign wd_flag_o = wd_flag_ff;

  // Checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);

  a_oneshot_lo_stops: assert property (end_lo && !wr_tcw |=> run_lo == RUN_OFF)
    else $error("one-shot low half did not stop");
  a_cont_reload_lo: assert property (lo_evt && run_lo == RUN_CONT && !wr_cnt_lo && lo_live
    |=> cnt_lo_ff == WORD_ZERO)
    else $error("continuous low half did not reload");
  a_disabled_holds_lo: assert property (!wide && run_lo == RUN_OFF && !wr_cnt_lo && lo_live
    |=> $stable(cnt_lo_ff))
    else $error("disabled low half changed");
  a_hi_reset_hold: assert property (!hi_live |=> cnt_hi_ff == WORD_ZERO)
    else $error("high half counted in reset");
  a_gate_blocks_count: assert property (!wide && !src_pin && gate_on && !tin_s2_ff
    && !wr_cnt_lo && lo_live |=> $stable(cnt_lo_ff))
    else $error("gated low half counted");
  a_pulse_four_long: assert property (evt_h[0] && !g_out[0].cp && g_out[0].pw == 2'h3
    |=> g_out[0].pul_on_ff [*4])
    else $error("pulse shorter than four clocks");
  a_clock_mode_toggle: assert property (evt_h[1] |=> g_out[1].clk_lvl_ff != $past(g_out[1].clk_lvl_ff))
    else $error("clock mode level did not toggle");
  a_chain_hi_hold: assert property (mode == MODE_DUAL_CHAIN && !lo_evt && !wr_cnt_hi
    && hi_live |=> $stable(cnt_hi_ff))
    else $error("chained high half moved without low event");
  a_wd_flag_sets: assert property (wd_timeout |=> wd_flag_o)
    else $error("watchdog timeout not flagged");
  a_wd_service_clears: assert property (wd_service && lo_live && hi_live
    && !wr_cnt_lo && !wr_cnt_hi |=> cnt64 == 64'h0000_0000_0000_0000)
    else $error("watchdog service did not reset counter");
  a_read_one_cycle: assert property (!rd_i |=> rdata_o == WORD_ZERO)
    else $error("read data outside its cycle");
  a_out_follows: assert property (1'b1 |=> tout_ff == $past(lvl_h))
    else $error("status output lags level");

  a_oneshot_hi_stops: assert property (end_hi && !wr_tcw
    |=> run_hi == RUN_OFF)
    else $error("one-shot high half did not stop");
  a_oneshot_lo_holds: assert property (lo_evt && run_lo == RUN_ONCE && !wr_cnt_lo && lo_live
    |=> $stable(cnt_lo_ff))
    else $error("one-shot low half moved after its period");
  a_cont_reload_hi: assert property (hi_evt && run_hi == RUN_CONT && !wr_cnt_hi && hi_live
    |=> cnt_hi_ff == WORD_ZERO)
    else $error("continuous high half did not reload");
  a_disabled_holds_hi: assert property (!wide && run_hi == RUN_OFF && !wr_cnt_hi && hi_live
    |=> $stable(cnt_hi_ff))
    else $error("disabled high half changed");
  a_lo_reset_hold: assert property (!lo_live
    |=> cnt_lo_ff == WORD_ZERO)
    else $error("low half counted in reset");

  a_load_lo_count: assert property (wr_cnt_lo && lo_live
    |=> cnt_lo_ff == $past(wdata_i))
    else $error("low count load lost");
  a_load_hi_count: assert property (wr_cnt_hi && hi_live
    |=> cnt_hi_ff == $past(wdata_i))
    else $error("high count load lost");
  a_period_lo_write: assert property (wr_i && addr_i == ADR_PRD_LO
    |=> prd_lo_ff == $past(wdata_i))
    else $error("low period write lost");
  a_period_hi_write: assert property (wr_i && addr_i == ADR_PRD_HI
    |=> prd_hi_ff == $past(wdata_i))
    else $error("high period write lost");
  a_tcw_write: assert property (wr_tcw
    |=> tcw_ff == ($past(wdata_i) & TCW_WMASK))
    else $error("timer control write lost");
  a_gcw_write: assert property (wr_gcw
    |=> gcw_ff == ($past(wdata_i) & GCW_WMASK))
    else $error("global control write lost");

  a_lo_step_one: assert property (step_lo && !lo_evt && !wr_cnt_lo && lo_live
    |=> cnt_lo_ff == $past(cnt_lo_ff) + WORD_ONE)
    else $error("low half step not one");
  a_hi_step_one: assert property (mode == MODE_DUAL_FREE && step_hi && !hi_evt
    && !wr_cnt_hi && hi_live |=> cnt_hi_ff == $past(cnt_hi_ff) + WORD_ONE)
    else $error("free high half step not one");
  a_chain_step_hi: assert property (mode == MODE_DUAL_CHAIN && step_hi && !hi_evt
    && !wr_cnt_hi && hi_live |=> cnt_hi_ff == $past(cnt_hi_ff) + WORD_ONE)
    else $error("chained high half step not one");
  a_wide_carry: assert property (step64 && !evt64 && !wd_service && !wr_cnt_lo
    && !wr_cnt_hi && lo_live && hi_live |=> cnt64 == $past(cnt64) + 64'h0000_0000_0000_0001)
    else $error("64-bit step not one");
  a_prescale_step: assert property (hi_en && hi_src && !pre_hit
    |=> pre_ff == $past(pre_ff) + 8'h01)
    else $error("prescaler did not advance");
  a_pin_edge_only: assert property (src_pin && !wide && !pin_rise && !wr_cnt_lo && lo_live
    |=> $stable(cnt_lo_ff))
    else $error("pin source counted without edge");
  a_clock_mode_hold: assert property (!evt_h[0]
    |=> g_out[0].clk_lvl_ff == $past(g_out[0].clk_lvl_ff))
    else $error("clock mode level moved without event");

  a_wd_stop_flagged: assert property (wd_mode && wd_flag_ff && !wd_service && !wr_cnt_lo
    && !wr_cnt_hi && lo_live && hi_live |=> $stable(cnt64))
    else $error("expired watchdog kept counting");
  a_wd_reload_zero: assert property (wd_timeout && !wr_cnt_lo && !wr_cnt_hi
    && lo_live && hi_live |=> cnt64 == 64'h0000_0000_0000_0000)
    else $error("expired watchdog did not restart at zero");
  a_wd_flag_holds: assert property (wd_flag_ff && !flag_clr
    |=> wd_flag_ff)
    else $error("watchdog flag dropped without clear");
  a_wd_flag_quiet: assert property (!wd_flag_ff && !wd_timeout
    |=> !wd_flag_ff)
    else $error("watchdog flag set without timeout");
  a_wd_unarmed_idle: assert property (wd_mode && !wd_armed_ff && !wd_service && !wr_cnt_lo
    && !wr_cnt_hi && lo_live && hi_live |=> $stable(cnt64))
    else $error("unarmed watchdog counted");
  a_wd_key_order: assert property (wd_mode && !wd_armed_ff && wdk_ff == WDK_IDLE
    |=> !wd_armed_ff)
    else $error("watchdog armed without first key");

  a_stat_out_read: assert property (rd_i && addr_i == ADR_STAT
    |=> rdata_o[STAT_OUT_LO] == $past(tout_lo_o)
    && rdata_o[STAT_OUT_HI] == $past(tout_hi_o))
    else $error("status read shows wrong output level");
  a_stat_run_read: assert property (rd_i && addr_i == ADR_STAT
    |=> rdata_o[STAT_RUN_LO] == $past(lo_en))
    else $error("status read shows wrong run state");
  a_wdcw_flag_read: assert property (rd_i && addr_i == ADR_WDCW
    |=> rdata_o[WDCW_FLAG] == $past(wd_flag_ff))
    else $error("watchdog word read shows wrong flag");

  c_chain_hi_event: cover property (mode == MODE_DUAL_CHAIN && hi_evt);
  c_wd_timeout: cover property (wd_timeout);
  c_oneshot_end: cover property (end_lo ##1 !lo_en);
  c_gp64_wrap: cover property (evt64 && cont64);
  c_prescale_step: cover property (mode == MODE_DUAL_FREE && step_hi && psc != PSC_ZERO);
endmodule : dht_timer

// file: hw/dht_pkg.sv
package dht_pkg;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 8;
  // Register byte addresses
  localparam logic [7:0] ADR_CNT_LO = 8'h00;
  localparam logic [7:0] ADR_CNT_HI = 8'h04;
  localparam logic [7:0] ADR_PRD_LO = 8'h08;
  localparam logic [7:0] ADR_PRD_HI = 8'h0C;
  localparam logic [7:0] ADR_TCW = 8'h10;
  localparam logic [7:0] ADR_GCW = 8'h14;
  localparam logic [7:0] ADR_WDCW = 8'h18;
  localparam logic [7:0] ADR_STAT = 8'h1C;
  // Timer control word: run and output fields per half, high half shifted by HALF_OFS; SRC, GATE and INVIN exist in the low half only
  localparam int unsigned HALF_OFS = 16;
  localparam int unsigned TCW_RUN = 0;
  localparam int unsigned TCW_SRC = 2;
  localparam int unsigned TCW_GATE = 3;
  localparam int unsigned TCW_INVIN = 4;
  localparam int unsigned TCW_PW = 5;
  localparam int unsigned TCW_CP = 7;
  localparam int unsigned TCW_INVO = 8;
  localparam logic [31:0] TCW_WMASK = 32'h01E3_01FF;
  // Global control word
  localparam int unsigned GCW_LO_RUN_N = 0;
  localparam int unsigned GCW_HI_RUN_N = 1;
  localparam int unsigned GCW_MODE = 2;
  localparam int unsigned GCW_PSC = 8;
  localparam logic [31:0] GCW_WMASK = 32'h0000_FF0F;
  // Watchdog control word
  localparam int unsigned WDCW_KEY = 16;
  localparam int unsigned WDCW_FLAG = 15;
  localparam int unsigned WDCW_ARMED = 14;
  // Key sequence values, arbitrary
  localparam logic [15:0] WD_KEY_FIRST = 16'hA5C6;
  localparam logic [15:0] WD_KEY_SECOND = 16'hDA7E;
  // Status register
  localparam int unsigned STAT_RUN_LO = 0;
  localparam int unsigned STAT_RUN_HI = 1;
  localparam int unsigned STAT_OUT_LO = 2;
  localparam int unsigned STAT_OUT_HI = 3;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  localparam logic [31:0] WORD_ONE = 32'h0000_0001;
  localparam logic [7:0] PSC_ZERO = 8'h00;
  localparam logic [1:0] PW_ZERO = 2'h0;

  typedef enum logic [1:0] {
    MODE_GP64 = 2'h0,
    MODE_DUAL_FREE = 2'h1,
    MODE_WATCHDOG = 2'h2,
    MODE_DUAL_CHAIN = 2'h3
  } dht_mode_t;

  typedef enum logic [1:0] {
    RUN_OFF = 2'h0,
    RUN_ONCE = 2'h1,
    RUN_CONT = 2'h2
  } dht_run_t;

  typedef enum logic {
    WDK_IDLE = 1'b0,
    WDK_FIRST = 1'b1
  } dht_wdk_t;
endpackage : dht_pkg

// file: testbench/dht_pin_model.sv
`timescale 1ns/100ps
module dht_pin_model (
  input wire logic mclk_i,
  input wire logic run_i,
  input wire logic level_i,
  output logic tin_o
);
  logic [1:0] ph_ff = 2'h0;
  // Square wave of four clocks while commanded, else a held level
  always_ff @(posedge mclk_i) begin
    ph_ff <= ph_ff + 2'h1;
  end
  assign tin_o = run_i ? ph_ff[1] : level_i;
endmodule : dht_pin_model

// file: testbench/tb.sv
`timescale 1ns/100ps
module tb import dht_pkg::*; ;
  logic mclk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic pin_run = 1'b0;
  logic pin_lvl = 1'b0;
  logic [31:0] rdata;
  logic tin;
  logic tout_lo;
  logic tout_hi;
  logic wd_flag;
  logic t0;
  logic [31:0] d;
  logic [31:0] a;
  int n_mismatch = 0;
  int checks = 0;
  int cycles = 0;
  int k;
  always #12.5 mclk_i = ~mclk_i;
  dht_timer dut (.mclk_i(mclk_i), .nrst_i(nrst_i), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .tin_i(tin), .tout_lo_o(tout_lo),
    .tout_hi_o(tout_hi), .wd_flag_o(wd_flag));
  dht_pin_model pin (.mclk_i(mclk_i), .run_i(pin_run), .level_i(pin_lvl), .tin_o(tin));
  task automatic end_of_test;
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_of_test
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
  endtask : cyc
  // Range compare; an unknown never passes
  task automatic chk(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    checks++;
    if ($isunknown(got) || got < lo || got > hi) begin
      $display("BAD %0t got %h want %h..%h", $time, got, lo, hi);
      n_mismatch++;
    end
  endtask : chk
  // Gap cycle after each strobe keeps one assignment per time step
  task automatic wr_reg(input logic [7:0] ad, input logic [31:0] v);
    addr <= ad;
    wdata <= v;
    wr <= 1'b1;
    @(posedge mclk_i);
    wr <= 1'b0;
    @(posedge mclk_i);
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] ad);
    addr <= ad;
    rd <= 1'b1;
    @(posedge mclk_i);
    rd <= 1'b0;
    @(negedge mclk_i);
    d = rdata;
    @(posedge mclk_i);
  endtask : rd_reg
  task automatic rdc(input logic [7:0] ad, input logic [31:0] e);
    rd_reg(ad);
    chk(d, e, e);
  endtask : rdc
  task automatic count_out(input logic inv);
    k = 0;
    repeat (20) begin
      @(negedge mclk_i);
      if (tout_lo !== inv) k++;
    end
    @(posedge mclk_i);
  endtask : count_out
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 4000) begin
      $display("BAD %0t timeout", $time);
      n_mismatch++;
      end_of_test;
    end
  end
  initial begin
    cyc(5);
    nrst_i <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      rdc(8'(i * 4), WORD_ZERO);
    end
    wr_reg(ADR_GCW, 32'h0000_0007);
    wr_reg(ADR_PRD_LO, 32'h0000_0005);
    rdc(ADR_PRD_LO, 32'h0000_0005);
    wr_reg(ADR_TCW, 32'h0000_0002);
    cyc(30);
    wr_reg(ADR_TCW, WORD_ZERO);
    rd_reg(ADR_CNT_LO);
    a = d;
    chk(a, 0, 5);
    cyc(5);
    rdc(ADR_CNT_LO, a);
    wr_reg(ADR_CNT_LO, 32'h0000_0003);
    rdc(ADR_CNT_LO, 32'h0000_0003);
    for (int v = 0; v < 2; v++) begin
      for (int p = 0; p < 4; p++) begin
        wr_reg(ADR_TCW, 32'(v << 8));
        wr_reg(ADR_CNT_LO, WORD_ZERO);
        wr_reg(ADR_PRD_LO, 32'h0000_0003);
        wr_reg(ADR_TCW, 32'(1 + (p << 5) + (v << 8)));
        count_out(v[0]);
        chk(k, p + 1, p + 1);
        rdc(ADR_TCW, 32'((p << 5) + (v << 8)));
        rdc(ADR_CNT_LO, 32'h0000_0003);
        rdc(ADR_STAT, 32'(v << 2));
      end
    end
    wr_reg(ADR_TCW, 32'h0000_0180);
    @(negedge mclk_i);
    t0 = tout_lo;
    @(posedge mclk_i);
    wr_reg(ADR_CNT_LO, WORD_ZERO);
    wr_reg(ADR_TCW, 32'h0000_0181);
    cyc(12);
    chk({31'h0, tout_lo}, {31'h0, ~t0}, {31'h0, ~t0});
    // Prescale 3: one high increment per four clocks
    wr_reg(ADR_GCW, 32'h0000_0307);
    wr_reg(ADR_PRD_HI, 32'hFFFF_FFFF);
    wr_reg(ADR_TCW, 32'h0102_0000);
    cyc(38);
    chk({31'h0, tout_hi}, WORD_ONE, WORD_ONE);
    rdc(ADR_STAT, 32'h0000_000A);
    wr_reg(ADR_TCW, WORD_ZERO);
    rd_reg(ADR_CNT_HI);
    chk(d, 9, 11);
    rdc(ADR_CNT_LO, 32'h0000_0003);
    wr_reg(ADR_GCW, 32'h0000_0305);
    rdc(ADR_CNT_HI, WORD_ZERO);
    wr_reg(ADR_GCW, 32'h0000_000F);
    wr_reg(ADR_CNT_LO, WORD_ZERO);
    wr_reg(ADR_PRD_LO, 32'h0000_0001);
    wr_reg(ADR_TCW, 32'h0002_0002);
    cyc(40);
    wr_reg(ADR_TCW, WORD_ZERO);
    rd_reg(ADR_CNT_HI);
    chk(d, 19, 22);
    wr_reg(ADR_GCW, 32'h0000_0003);
    wr_reg(ADR_PRD_HI, 32'h0000_0001);
    wr_reg(ADR_PRD_LO, 32'hFFFF_FFFF);
    wr_reg(ADR_CNT_HI, WORD_ZERO);
    wr_reg(ADR_CNT_LO, 32'hFFFF_FFF0);
    wr_reg(ADR_TCW, 32'h0000_0002);
    cyc(30);
    wr_reg(ADR_TCW, WORD_ZERO);
    rdc(ADR_CNT_HI, WORD_ONE);
    wr_reg(ADR_GCW, 32'h0000_0007);
    wr_reg(ADR_CNT_LO, WORD_ZERO);
    wr_reg(ADR_TCW, 32'h0000_000A);
    cyc(10);
    rdc(ADR_CNT_LO, WORD_ZERO);
    pin_lvl <= 1'b1;
    cyc(10);
    wr_reg(ADR_TCW, WORD_ZERO);
    rd_reg(ADR_CNT_LO);
    chk(d, 6, 14);
    wr_reg(ADR_CNT_LO, WORD_ZERO);
    wr_reg(ADR_TCW, 32'h0000_0016);
    cyc(6);
    pin_lvl <= 1'b0;
    cyc(8);
    rdc(ADR_CNT_LO, WORD_ONE);
    wr_reg(ADR_CNT_LO, WORD_ZERO);
    wr_reg(ADR_TCW, 32'h0000_0006);
    pin_lvl <= 1'b1;
    cyc(8);
    pin_lvl <= 1'b0;
    cyc(8);
    rdc(ADR_CNT_LO, WORD_ONE);
    pin_run <= 1'b1;
    cyc(40);
    pin_run <= 1'b0;
    cyc(6);
    rd_reg(ADR_CNT_LO);
    chk(d, 10, 12);
    wr_reg(ADR_GCW, 32'h0000_000B);
    wr_reg(ADR_PRD_HI, WORD_ZERO);
    wr_reg(ADR_PRD_LO, 32'h0000_0014);
    wr_reg(ADR_TCW, 32'h0000_0002);
    // Out-of-order keys must not arm
    wr_reg(ADR_WDCW, {WD_KEY_SECOND, 16'h0000});
    wr_reg(ADR_WDCW, {WD_KEY_FIRST, 16'h0000});
    wr_reg(ADR_WDCW, 32'h1234_0000);
    wr_reg(ADR_WDCW, {WD_KEY_SECOND, 16'h0000});
    rd_reg(ADR_WDCW);
    chk(d & 32'h0000_C000, WORD_ZERO, WORD_ZERO);
    cyc(30);
    chk({31'h0, wd_flag}, WORD_ZERO, WORD_ZERO);
    for (int s = 0; s < 2; s++) begin
      wr_reg(ADR_WDCW, {WD_KEY_FIRST, 16'h0000});
      wr_reg(ADR_WDCW, {WD_KEY_SECOND, 16'h0000});
      cyc(10);
    end
    chk({31'h0, wd_flag}, WORD_ZERO, WORD_ZERO);
    cyc(20);
    chk({31'h0, wd_flag}, WORD_ONE, WORD_ONE);
    rd_reg(ADR_WDCW);
    chk(d & 32'h0000_C000, 32'h0000_C000, 32'h0000_C000);
    wr_reg(ADR_WDCW, 32'h0000_8000);
    chk({31'h0, wd_flag}, WORD_ZERO, WORD_ZERO);
    cyc(30);
    chk({31'h0, wd_flag}, WORD_ONE, WORD_ONE);
    end_of_test;
  end
endmodule : tb
